// file: hdl/aec_pkg.sv
// Constants and types shared by the axis enable controller
package aec_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CTRL_CYCLE_NS = 1000;
  localparam int unsigned TICK_CYCLES   = CTRL_CYCLE_NS / CLK_PERIOD_NS;
  localparam int          TICK_W        = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int        ADR_W      = 8;
  localparam int        DAT_W      = 32;
  localparam int        VEL_W      = 16;
  localparam logic [ADR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_FAULT  = 8'h08;
  localparam logic [ADR_W-1:0] REG_DECEL  = 8'h0c;
  localparam logic [ADR_W-1:0] REG_JERK   = 8'h10;
  localparam logic [ADR_W-1:0] REG_TASK   = 8'h14;
  localparam logic [ADR_W-1:0] REG_CMD    = 8'h18;

  localparam int CTRL_W     = 5;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_STY   = 1;
  localparam int CTRL_DOK   = 3;
  localparam int CTRL_JERK  = 4;
  localparam int CMD_W      = 2;
  localparam int CMD_ACK    = 0;
  localparam int CMD_HOME   = 1;
  localparam int FAULT_DET  = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h00;
  localparam logic [VEL_W-1:0]  DECEL_RST = 16'h0010;
  localparam logic [VEL_W-1:0]  JERK_RST  = 16'h0001;

  // ----------------------------------------------------------------
  // Halt styles and fault codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HALT_EMERG = 2'h0;
  localparam logic [1:0] HALT_IMMED = 2'h1;
  localparam logic [1:0] HALT_JERK  = 2'h2;
  localparam logic [15:0] FC_NONE        = 16'h0000;
  localparam logic [15:0] FC_DRIVE_LOST  = 16'h0001;
  localparam logic [15:0] FC_DRIVE_FAULT = 16'h0002;
  localparam logic [15:0] FC_BAD_STYLE   = 16'h0003;
  localparam logic [15:0] FC_TASK_REJECT = 16'h0004;

  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_WAIT  = 5'h02,
    ST_ON    = 5'h04,
    ST_STOP  = 5'h08,
    ST_FAULT = 5'h10
  } aec_state_t;

endpackage : aec_pkg

// file: hdl/aec_motion_if.sv
// Link between enable control and the pulse generator
`timescale 1ns/1ns
interface aec_motion_if;
  import aec_pkg::*;
  logic             tick;
  logic             run;
  logic             halt;
  logic             ramp;
  logic             jerk_on;
  logic [VEL_W-1:0] target;
  logic [VEL_W-1:0] decel;
  logic [VEL_W-1:0] jerk;
  logic             still;
  logic             pulse;
  modport ctl (output tick, run, halt, ramp, jerk_on, target, decel, jerk,
               input still, pulse);
  modport mot (input tick, run, halt, ramp, jerk_on, target, decel, jerk,
               output still, pulse);
endinterface : aec_motion_if

// file: hdl/aec_motion.sv
// Velocity ramp and pulse train generator for one axis
`timescale 1ns/1ns
module aec_motion (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  aec_motion_if.mot  m
);
  import aec_pkg::*;

  typedef struct packed {
    logic [VEL_W-1:0] vel;
    logic [VEL_W-1:0] rate;
    logic [VEL_W-1:0] acc;
    logic             pulse;
    logic             still;
  } aec_mot_t;

  aec_mot_t s;
  aec_mot_t n;
  logic [VEL_W:0] sum;
  logic [VEL_W:0] nrate;

  always_comb begin
    n        = s;
    sum      = {1'b0, s.acc} + {1'b0, s.vel};
    nrate    = {1'b0, s.rate} + {1'b0, m.jerk};
    n.acc    = sum[VEL_W-1:0];
    n.pulse  = sum[VEL_W] && (s.vel != '0);
    if (m.halt) begin
      // Halt is not tied to the tick: waiting for it would let pulses run on
      n.vel   = '0;
      n.rate  = '0;
      n.pulse = 1'b0;
    end else if (m.tick) begin
      if (m.ramp) begin
        if (!m.jerk_on || nrate[VEL_W] || nrate[VEL_W-1:0] >= m.decel) begin
          n.rate = m.decel;
        end else begin
          n.rate = nrate[VEL_W-1:0];
        end
        n.vel = (s.vel > n.rate) ? s.vel - n.rate : '0;
      end else if (m.run) begin
        n.vel  = m.target;
        n.rate = '0;
      end
    end
    n.still = (n.vel == '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s       <= '0;
      s.still <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign m.pulse = s.pulse;
  assign m.still = s.still;

endmodule : aec_motion

// file: hdl/aec_top.sv
// Axis enable controller with Wishbone register access
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns

// Functional notes
// - Enable request high makes the block try to enable the axis.
// - Enable request low (default) aborts motion per halt style and stops axis.
// - Style 0 ramps down at emergency rate, disabled only at standstill.
// - Style 1 disables at once, pulse output halts with no ramp.
// - Style 2 brakes at emergency rate, adds jerk limit when enabled.
// - Disabled axis counts as not homed; homed indication cleared.
// - While disabling, status stays high until standstill, then drops; with style 1 the code drops it at once, without waiting for standstill.
// - With drive-ok configured, status stays low until drive-ok arrives.
// - Without drive-ok configured, status rises straight on enable request.
// - Busy output high while the enable function is active.
// - Faults raise error output with fault code and detail words.
// - On enable the drive power output rises first, then drive-ok is awaited.
// - Drive raises drive-ok once powered; then status and enabled flag set.
// - Motion tasks never abort the enable function.
// - Fault switch-off re-enables after fault cleared and acknowledged.
module aec_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [aec_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [aec_pkg::DAT_W-1:0] wb_dat_i,
  output logic [aec_pkg::DAT_W-1:0] wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 drive_ok_i,
  input  wire logic                 drive_fault_i,
  output logic                      drive_power_o,
  output logic                      pulse_train_o,
  output logic                      axis_status_o,
  output logic                      enabled_flag_o,
  output logic                      standstill_flag_o,
  output logic                      homed_o,
  output logic                      busy_o,
  output logic                      error_o,
  output logic [15:0]               fault_code_o,
  output logic [15:0]               fault_detail_o
);
  import aec_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    aec_state_t        st;
    logic [CTRL_W-1:0] ctrl;
    logic [VEL_W-1:0]  decel;
    logic [VEL_W-1:0]  jerk;
    logic [VEL_W-1:0]  tvel;
    logic [CMD_W-1:0]  cmd;
    logic [CMD_W-1:0]  cmd_d;
    logic              ackp;
    logic              en_s;
    logic [1:0]        sty_s;
    logic [TICK_W-1:0] tcnt;
    logic              tick;
    logic [2:0]        dsync;
    logic              dok;
    logic [2:0]        fsync;
    logic              flt;
    logic              pwr;
    logic              status;
    logic              busy;
    logic              error;
    logic [15:0]       code;
    logic [15:0]       detail;
    logic              homed;
    logic              run;
    logic              halt;
    logic              ramp;
    logic              jerk_on;
    logic              ack;
    logic [DAT_W-1:0]  dat;
  } aec_top_t;

  aec_top_t         s;
  aec_top_t         n;
  aec_motion_if     mif ();
  logic             req;
  logic [DAT_W-1:0] rdata;
  logic [DAT_W-1:0] wmask;
  logic [DAT_W-1:0] wval;
  logic [DAT_W-1:0] cur;
  logic             fault_now;

  // ----------------------------------------------------------------
  // Bus read mux and byte-lane merge
  // ----------------------------------------------------------------
  always_comb begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    rdata = '0;
    case (wb_adr_i)
      REG_CTRL: begin
        rdata[CTRL_W-1:0] = s.ctrl;
      end
      REG_STATUS: begin
        rdata[6:0] = {s.dok, s.pwr, s.homed, mif.still,
                      s.error, s.busy, s.status};
      end
      REG_FAULT: begin
        rdata = {s.detail, s.code};
      end
      REG_DECEL: begin
        rdata[VEL_W-1:0] = s.decel;
      end
      REG_JERK: begin
        rdata[VEL_W-1:0] = s.jerk;
      end
      REG_TASK: begin
        rdata[VEL_W-1:0] = s.tvel;
      end
      REG_CMD: begin
        rdata[CMD_W-1:0] = s.cmd;
      end
      default: begin
        rdata = '0;
      end
    endcase
    cur  = rdata;
    wval = (cur & ~wmask) | (wb_dat_i & wmask);
  end

  assign req = wb_cyc_i && wb_stb_i && !s.ack;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n     = s;
    n.ack = 1'b0;
    n.tick = 1'b0;
    // Control cycle divider
    if (s.tcnt == TICK_LAST) begin
      n.tcnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tcnt = s.tcnt + 1'b1;
    end

    // Pin inputs: three stages, change taken when last two agree
    n.dsync = {s.dsync[1:0], drive_ok_i};
    n.fsync = {s.fsync[1:0], drive_fault_i};
    if (s.dsync[1] == s.dsync[2]) begin
      n.dok = s.dsync[2];
    end
    if (s.fsync[1] == s.fsync[2]) begin
      n.flt = s.fsync[2];
    end

    fault_now = s.flt || (s.ctrl[CTRL_DOK] && !s.dok);

    if (s.tick) begin
      // Levels sampled now, acted on at the next tick
      n.en_s  = s.ctrl[CTRL_EN];
      n.sty_s = s.ctrl[CTRL_STY +: 2];
      // Acknowledge clears latched errors except a live fault
      if (s.ackp && s.st != ST_FAULT) begin
        n.ackp   = 1'b0;
        n.error  = 1'b0;
        n.code   = FC_NONE;
        n.detail = '0;
      end
      case (s.st)
        ST_OFF: begin
          n.run  = 1'b0;
          n.halt = 1'b1;
          if (s.en_s && !s.error) begin
            if (s.sty_s > HALT_JERK) begin
              n.error  = 1'b1;
              n.code   = FC_BAD_STYLE;
              n.detail = {14'h0000, s.sty_s};
            end else begin
              n.pwr = 1'b1;
              if (s.ctrl[CTRL_DOK]) begin
                n.st = ST_WAIT;
              end else begin
                n.st     = ST_ON;
                n.status = 1'b1;
                n.run    = 1'b1;
                n.halt   = 1'b0;
              end
            end
          end
        end
        ST_WAIT: begin
          if (!s.en_s) begin
            n.pwr = 1'b0;
            n.st  = ST_OFF;
          end else if (s.flt) begin
            n.st     = ST_FAULT;
            n.pwr    = 1'b0;
            n.error  = 1'b1;
            n.code   = FC_DRIVE_FAULT;
            n.detail = 16'(s.st);
          end else if (s.dok) begin
            n.st     = ST_ON;
            n.status = 1'b1;
            n.run    = 1'b1;
            n.halt   = 1'b0;
          end
        end
        ST_ON, ST_STOP: begin
          if (fault_now) begin
            // Drive gone: pulses cut at once, no ramp possible
            n.st      = ST_FAULT;
            n.pwr     = 1'b0;
            n.status  = 1'b0;
            n.run     = 1'b0;
            n.ramp    = 1'b0;
            n.halt    = 1'b1;
            n.error   = 1'b1;
            n.code    = s.flt ? FC_DRIVE_FAULT : FC_DRIVE_LOST;
            n.detail  = 16'(s.st);
          end else if (s.st == ST_STOP) begin
            if (mif.still) begin
              n.st     = ST_OFF;
              n.status = 1'b0;
              n.pwr    = 1'b0;
              n.ramp   = 1'b0;
              n.halt   = 1'b1;
            end
          end else if (!s.en_s) begin
            n.run = 1'b0;
            if (s.sty_s == HALT_IMMED) begin
              n.st     = ST_OFF;
              n.halt   = 1'b1;
              n.status = 1'b0;
              n.pwr    = 1'b0;
            end else begin
              n.st      = ST_STOP;
              n.ramp    = 1'b1;
              n.jerk_on = (s.sty_s == HALT_JERK)
                          && s.ctrl[CTRL_JERK];
            end
          end
        end
        ST_FAULT: begin
          // Leaving to OFF lets a held enable bring the axis back
          if (s.ackp && !s.flt) begin
            n.ackp   = 1'b0;
            n.error  = 1'b0;
            n.code   = FC_NONE;
            n.detail = '0;
            n.st     = ST_OFF;
          end
        end
        default: begin
          n.st     = ST_OFF;
          n.pwr    = 1'b0;
          n.status = 1'b0;
          n.halt   = 1'b1;
          n.run    = 1'b0;
          n.ramp   = 1'b0;
        end
      endcase
    end

    // Acknowledge on rising edge of the command bit
    n.cmd_d = s.cmd;
    if (s.cmd[CMD_ACK] && !s.cmd_d[CMD_ACK]) begin
      n.ackp = 1'b1;
    end
    if (s.cmd[CMD_HOME] && !s.cmd_d[CMD_HOME] && s.st == ST_ON) begin
      n.homed = 1'b1;
    end

    // Bus access; writes come last so a new error beats a clear
    if (req) begin
      n.ack = 1'b1;
      n.dat = rdata;
      if (wb_we_i) begin
        case (wb_adr_i)
          REG_CTRL: begin
            n.ctrl = wval[CTRL_W-1:0];
          end
          REG_DECEL: begin
            n.decel = wval[VEL_W-1:0];
          end
          REG_JERK: begin
            n.jerk = wval[VEL_W-1:0];
          end
          REG_TASK: begin
            // A task only sets velocity, never the enable sequence
            if (s.st == ST_ON) begin
              n.tvel = wval[VEL_W-1:0];
            end else begin
              n.error  = 1'b1;
              n.code   = FC_TASK_REJECT;
              n.detail = 16'(s.st);
            end
          end
          REG_CMD: begin
            n.cmd = wval[CMD_W-1:0];
          end
          default: begin
            n.cmd = s.cmd;
          end
        endcase
      end
    end

    if (!n.status) begin
      n.homed = 1'b0;
    end
    n.busy = (n.st != ST_OFF) || n.en_s;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s       <= '0;
      s.st    <= ST_OFF;
      s.ctrl  <= CTRL_RST;
      s.decel <= DECEL_RST;
      s.jerk  <= JERK_RST;
      s.halt  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  assign mif.tick    = s.tick;
  assign mif.run     = s.run;
  assign mif.halt    = s.halt;
  assign mif.ramp    = s.ramp;
  assign mif.jerk_on = s.jerk_on;
  assign mif.target  = s.tvel;
  assign mif.decel   = s.decel;
  assign mif.jerk    = s.jerk;

  aec_motion aec_motion_i (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .m     (mif.mot)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o          = s.dat;
  assign wb_ack_o          = s.ack;
  assign drive_power_o     = s.pwr;
  assign pulse_train_o     = mif.pulse;
  assign axis_status_o     = s.status;
  assign enabled_flag_o    = s.status;
  assign standstill_flag_o = mif.still;
  assign homed_o           = s.homed;
  assign busy_o            = s.busy;
  assign error_o           = s.error;
  assign fault_code_o      = s.code;
  assign fault_detail_o    = s.detail;

endmodule : aec_top

// file: bench/aec_drive_model.sv
// Behavioural motor drive answering the power-on line with drive-ok
`timescale 1ns/1ns
module aec_drive_model #(
  parameter int FAST_DLY = 3,
  parameter int SLOW_DLY = 40
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic power_i,
  input  wire logic slow_i,
  input  wire logic fault_req_i,
  output logic      ok_o,
  output logic      fault_o
);
  int cnt_r;
  // ----------------------------------------------------------------
  // Ready follows power after a delay; released at once when unpowered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !power_i) begin
      cnt_r <= 0;
      ok_o  <= 1'b0;
    end else begin
      if (cnt_r < SLOW_DLY) cnt_r <= cnt_r + 1;
      ok_o <= (cnt_r >= (slow_i ? SLOW_DLY : FAST_DLY));
    end
  end
  assign fault_o = fault_req_i;
endmodule : aec_drive_model

// file: bench/aec_top_checker.sv
// Port-level assertions for the axis enable controller
`timescale 1ns/1ns
module aec_top_checker (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_ack_o,
  input wire logic                        drive_fault_i,
  input wire logic                        drive_power_o,
  input wire logic                        pulse_train_o,
  input wire logic                        axis_status_o,
  input wire logic                        enabled_flag_o,
  input wire logic                        homed_o,
  input wire logic                        busy_o,
  input wire logic                        error_o,
  input wire logic [15:0]                 fault_code_o
);
  import aec_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered next cycle");
  property p_status_flag; axis_status_o == enabled_flag_o; endproperty
  a_status_flag: assert property (p_status_flag) else $error("status and enabled flag differ");
  property p_status_power; axis_status_o |-> drive_power_o; endproperty
  a_status_power: assert property (p_status_power) else $error("enabled without drive power");
  property p_homed; !axis_status_o [*2] |-> !homed_o; endproperty
  a_homed: assert property (p_homed) else $error("homed while disabled");
  property p_busy; axis_status_o |-> busy_o; endproperty
  a_busy: assert property (p_busy) else $error("enabled axis not busy");
  property p_error_code; error_o |-> fault_code_o != FC_NONE; endproperty
  a_error_code: assert property (p_error_code) else $error("error without fault code");
  property p_fault_off;
    $rose(drive_fault_i) && drive_power_o |-> ##[1:520] (error_o && !drive_power_o);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("drive fault did not switch axis off");
  // Pulses may lag the power line by one register stage
  property p_no_pulse; !drive_power_o [*2] |-> !pulse_train_o; endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("pulses while disabled");
  property p_enable_react; $rose(busy_o) |-> ##[0:520] drive_power_o; endproperty
  a_enable_react: assert property (p_enable_react) else $error("enable request not acted on");
  c_enable: cover property ($rose(axis_status_o));
  c_disable: cover property ($fell(axis_status_o));
  c_fault: cover property ($rose(error_o));
endmodule : aec_top_checker
bind aec_top aec_top_checker aec_top_checker_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .drive_fault_i(drive_fault_i), .drive_power_o(drive_power_o),
  .pulse_train_o(pulse_train_o), .axis_status_o(axis_status_o), .enabled_flag_o(enabled_flag_o),
  .homed_o(homed_o), .busy_o(busy_o), .error_o(error_o), .fault_code_o(fault_code_o));

// file: bench/aec_top_test.sv
// Self-checking bench for the axis enable controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
`define WAITFOR(c, n, k) k = 0; while (!(c) && k < n) begin @(posedge clk_i); k++; end
module axis_enable_control_test;
  import aec_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, slow = 0, fault_req = 0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0]       wb_sel_i = '0;
  logic [DAT_W-1:0] wb_dat_i = '0, wb_dat_o, rd;
  logic wb_ack_o, drive_ok, drive_fault, drive_power_o, pulse_train_o, axis_status_o;
  logic enabled_flag_o, standstill_flag_o, homed_o, busy_o, error_o;
  logic [15:0] fault_code_o, fault_detail_o;
  int mismatches = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  aec_top aec_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .drive_ok_i(drive_ok), .drive_fault_i(drive_fault), .drive_power_o(drive_power_o),
    .pulse_train_o(pulse_train_o), .axis_status_o(axis_status_o), .enabled_flag_o(enabled_flag_o),
    .standstill_flag_o(standstill_flag_o), .homed_o(homed_o), .busy_o(busy_o), .error_o(error_o),
    .fault_code_o(fault_code_o), .fault_detail_o(fault_detail_o));
  aec_drive_model aec_drive_model_i (.clk_i(clk_i), .rst_i(rst_i), .power_i(drive_power_o), .slow_i(slow),
    .fault_req_i(fault_req), .ok_o(drive_ok), .fault_o(drive_fault));
  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
    `CHK("bus ack latency", 2, k)
  endtask : wb_xfer
  task automatic pulses(input int n, output int c);
    c = 0;
    repeat (n) begin @(posedge clk_i); if (pulse_train_o === 1'b1) c++; end
  endtask : pulses
  task automatic fault_ack();
    wb_xfer(1, REG_CMD, 32'h0);
    wb_xfer(1, REG_CMD, 32'h1);
  endtask : fault_ack
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wb_xfer(0, REG_CTRL, 32'h0); `CHK("ctrl reset", 32'h0, rd)
    wb_xfer(0, REG_DECEL, 32'h0); `CHK("decel reset", 32'h10, rd)
    wb_xfer(0, REG_JERK, 32'h0); `CHK("jerk reset", 32'h1, rd)
    wb_xfer(1, 8'h1c, 32'hffff_ffff); wb_xfer(0, 8'h1c, 32'h0); `CHK("unmapped", 32'h0, rd)
    `CHK("standstill reset", 1'b1, standstill_flag_o)
    `CHK("busy reset", 1'b0, busy_o)
  endtask : t_reset
  task automatic t_reject();
    int w, c;
    wb_xfer(1, REG_TASK, 32'h4000);
    `WAITFOR(error_o, 10, w)
    `CHK("reject error", 1'b1, error_o)
    `CHK("reject code", FC_TASK_REJECT, fault_code_o)
    pulses(40, c); `CHK("reject pulses", 0, c)
    fault_ack();
    `WAITFOR(!error_o, 600, w)
    `CHK("reject cleared", 1'b0, error_o)
  endtask : t_reject
  task automatic t_run(input logic [1:0] sty, input logic jk, input logic cfg);
    int w, c;
    logic [DAT_W-1:0] cw;
    cw = {27'h0, jk, cfg, sty, 1'b0};
    wb_xfer(1, REG_DECEL, 32'h1000);
    wb_xfer(1, REG_JERK, 32'h400);
    wb_xfer(1, REG_CTRL, cw);
    wb_xfer(1, REG_CTRL, cw | 32'h1);
    `WAITFOR(drive_power_o, 600, w)
    `CHK("enable reaction", 1'b1, w >= 240)
    `CHK("status at power", !cfg, axis_status_o)
    `WAITFOR(axis_status_o, 800, w)
    `CHK("status", 1'b1, axis_status_o)
    `CHK("enabled flag", 1'b1, enabled_flag_o)
    wb_xfer(0, REG_STATUS, 32'h0); `CHK("status reg", 2'h3, rd[1:0])
    wb_xfer(1, REG_CMD, 32'h2);
    wb_xfer(1, REG_TASK, 32'h4000);
    // New velocity is taken at the next control tick, up to 250 clocks away
    pulses(300, c);
    `CHK("homed", 1'b1, homed_o)
    `CHK("moving", 1'b1, c > 5)
    wb_xfer(1, REG_CTRL, cw);
    `WAITFOR(!axis_status_o, 3000, w)
    if (sty == HALT_IMMED) begin
      `CHK("immediate stop", 1'b1, w < 600)
      pulses(20, c); `CHK("no pulses", 0, c)
    end else begin
      `CHK("ramped stop", 1'b1, w >= 300)
      `CHK("still at off", 1'b1, standstill_flag_o)
    end
    repeat (2) @(posedge clk_i);
    `CHK("busy off", 1'b0, busy_o)
    `CHK("power off", 1'b0, drive_power_o)
    `CHK("homed off", 1'b0, homed_o)
    wb_xfer(1, REG_CMD, 32'h0);
  endtask : t_run
  task automatic t_fault();
    int w;
    wb_xfer(1, REG_CTRL, 32'h1);
    `WAITFOR(axis_status_o, 800, w)
    @(posedge clk_i) fault_req <= 1;
    `WAITFOR(error_o, 600, w)
    `CHK("fault code", FC_DRIVE_FAULT, fault_code_o)
    `CHK("fault detail", 1'b1, fault_detail_o != 16'h0)
    `CHK("fault status", 1'b0, axis_status_o)
    wb_xfer(0, REG_FAULT, 32'h0); `CHK("fault reg", {fault_detail_o, FC_DRIVE_FAULT}, rd)
    @(posedge clk_i) fault_req <= 0;
    repeat (10) @(posedge clk_i);
    fault_ack();
    `WAITFOR(axis_status_o, 1500, w)
    `CHK("re-enabled", 1'b1, axis_status_o)
    `CHK("error gone", 1'b0, error_o)
    wb_xfer(1, REG_TASK, 32'h0);
    `WAITFOR(standstill_flag_o, 600, w)
    `CHK("rest before disable", 1'b1, standstill_flag_o)
    wb_xfer(1, REG_CTRL, 32'h0);
    `WAITFOR(!busy_o, 3000, w)
    `CHK("fault busy off", 1'b0, busy_o)
  endtask : t_fault
  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_reject();
    t_run(HALT_EMERG, 1'b0, 1'b0);
    slow <= 1;
    t_run(HALT_IMMED, 1'b0, 1'b1);
    slow <= 0;
    t_run(HALT_JERK, 1'b1, 1'b1);
    t_fault();
    tally_and_finish();
  end
  // Whole run needs about 10k cycles; the limit leaves a wide margin
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule : axis_enable_control_test
